// >>> hdl/lsp_defines.vh
`ifndef LSP_DEFINES_VH
`define LSP_DEFINES_VH

// register byte offsets
`define LSP_OFF_CTRL     8'h00
`define LSP_OFF_STATUS   8'h04
`define LSP_OFF_GPDIR    8'h08
`define LSP_OFF_GPVAL    8'h0C
`define LSP_OFF_IRQ_STAT 8'h10
`define LSP_OFF_IRQ_MASK 8'h14

// reset values of the general io registers
`define LSP_GPDIR_RST    4'h1
`define LSP_GPVAL_RST    4'h1

// status word bit positions
`define LSP_ST_READY     0
`define LSP_ST_LEDMODE   1
`define LSP_ST_REVMII    2
`define LSP_ST_LINK      3
`define LSP_ST_SPEED     4
`define LSP_ST_FDX       5
`define LSP_ST_CRS       6
`define LSP_ST_TEST_LO   8

// interrupt bit positions
`define LSP_IRQ_WAKE     0
`define LSP_IRQ_LINKCHG  1
`define LSP_IRQ_READY    2
`define LSP_IRQ_W        3

// ctrl bit positions
`define LSP_CTRL_WAKECLR 0

// timing
`define LSP_CLK_MHZ      200
`define LSP_READY_NS     5000
`define LSP_READY_CYC    ((`LSP_READY_NS * `LSP_CLK_MHZ + 999) / 1000)
`define LSP_CLK20_DIV    5
`define LSP_STRAP_CYC    16'h0003

// ahb
`define LSP_HTRANS_NSEQ  2'h2
`define LSP_HTRANS_SEQ   2'h3

`endif

// >>> hdl/lsp_clkdiv.v
`timescale 1ns/100ps
`include "lsp_defines.vh"

// divides mclk by ten for the 20 MHz mii clock
module lsp_clkdiv #(
	parameter HALF = `LSP_CLK20_DIV
) (
	input  wire mclk,
	input  wire nrst,
	output reg  clk_out_q
);
	reg [3:0] cnt_q;

	// toggle every HALF cycles, 50 percent duty
	always @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			cnt_q     <= 4'h0;
			clk_out_q <= 1'b0;
		end
		else if (cnt_q == HALF[3:0] - 4'h1)
		begin
			cnt_q     <= 4'h0;
			clk_out_q <= ~clk_out_q;
		end
		else
			cnt_q <= cnt_q + 4'h1;
	end
endmodule // lsp_clkdiv

// >>> hdl/lsp_pin_logic.v
// Functional notes
// [RULE1] eeprom select strap high picks led mode 1
// [RULE2] speed led low at 100M, float 10M
// [RULE3] mode 1: duplex led low on full duplex
// [RULE4] mode 0: duplex led low at 10M
// [RULE5] mode 1: activity led from link and carrier
// [RULE6] mode 0: activity led from carrier only
// [RULE7] gpio0 output high after reset, powers down phy
// [RULE8] gpio1 to 3 inputs after reset
// [RULE9] cable link output follows link state
// [RULE10] cable link strap high selects reversed mii
// [RULE11] wake output asserted on wake event
// [RULE12] ready 5 us after reset release
// [RULE13] board ties test straps to 1,1,0,0
// [RULE14] 20 MHz clock out for external mii
// [RULE15] straps sampled at reset release, then held
`timescale 1ns/100ps
`include "lsp_defines.vh"

module lsp_pin_logic #(
	parameter READY_CYC = `LSP_READY_CYC
) (
	input  wire        mclk,
	input  wire        nrst,
	// ahb-lite slave
	input  wire        hsel,
	input  wire [7:0]  haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output reg  [31:0] hrdata,
	output reg         hreadyout,
	output reg         hresp,
	output reg         irq,
	// phy state, from logic on mclk
	input  wire        phy_speed_led_n,
	input  wire        phy_full_duplex,
	input  wire        phy_link_up,
	input  wire        phy_carrier,
	input  wire        wake_event,
	// straps, pins
	input  wire        eeprom_select_strap,
	input  wire        cable_link_in,
	input  wire [3:0]  test_mode_straps,
	// led pins, open drain
	output reg         speed_led_n_o,
	output reg         speed_led_n_oe,
	output reg         duplex_led_n_o,
	output reg         duplex_led_n_oe,
	output reg         link_activity_led_n_o,
	output reg         link_activity_led_n_oe,
	// general io pins
	input  wire [3:0]  general_io_pins_i,
	output reg  [3:0]  general_io_pins_o,
	output reg  [3:0]  general_io_pins_oe,
	// misc outputs
	output reg         cable_link_out,
	output reg         cable_link_oe,
	output reg         wake_signal_out,
	output reg         device_ready,
	output reg         led_mode,
	output reg         reversed_mii,
	output wire        mii_clock_20m_out
);
	// pin synchronisers
	reg  [5:0]  sync1_q;
	reg  [5:0]  sync2_q;
	reg  [3:0]  gpi1_q;
	reg  [3:0]  gpi2_q;
	wire        ees_s  = sync2_q[0];
	wire        cls_s  = sync2_q[1];
	wire [3:0]  tst_s  = sync2_q[5:2];

	// two flops on every pin input
	always @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			sync1_q <= 6'h00;
			sync2_q <= 6'h00;
			gpi1_q  <= 4'h0;
			gpi2_q  <= 4'h0;
		end
		else
		begin
			sync1_q <= {test_mode_straps, cable_link_in,
				eeprom_select_strap};
			sync2_q <= sync1_q;
			gpi1_q  <= general_io_pins_i;
			gpi2_q  <= gpi1_q;
		end
	end

	// ready timer and strap capture
	// counter width covers the default delay at 200 MHz
	localparam RW = 16;
	reg [RW-1:0] rdy_cnt_q;
	reg          sampled_q;
	reg [3:0]    test_q;
	wire         cnt_done = (rdy_cnt_q == READY_CYC[RW-1:0]);

	// straps caught once after release: the sync chain has settled by
	// then because it starts at reset and needs only two edges
	always @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			rdy_cnt_q    <= {RW{1'b0}};
			sampled_q    <= 1'b0;
			led_mode     <= 1'b0;
			reversed_mii <= 1'b0;
			test_q       <= 4'h0;
			device_ready <= 1'b0;
		end
		else
		begin
			if (!cnt_done)
				rdy_cnt_q <= rdy_cnt_q + {{RW-1{1'b0}}, 1'b1};
			device_ready <= cnt_done; // RULE12
			if (!sampled_q && rdy_cnt_q == `LSP_STRAP_CYC)
			begin
				sampled_q    <= 1'b1;                   // RULE15
				led_mode     <= ees_s;                  // RULE1
				reversed_mii <= cls_s;                  // RULE10
				test_q       <= tst_s;                  // RULE13
			end
		end
	end

	// the link strap pin is only an input until straps are taken,
	// so the board pull decides the level while we sample it
	always @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			cable_link_out <= 1'b0;
			cable_link_oe  <= 1'b0;
		end
		else
		begin
			cable_link_oe  <= sampled_q;
			cable_link_out <= phy_link_up; // RULE9
		end
	end

	// led drive: open drain, oe high pulls the pin low
	always @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			speed_led_n_o          <= 1'b0;
			speed_led_n_oe         <= 1'b0;
			duplex_led_n_o         <= 1'b0;
			duplex_led_n_oe        <= 1'b0;
			link_activity_led_n_o  <= 1'b0;
			link_activity_led_n_oe <= 1'b0;
		end
		else
		begin
			speed_led_n_oe <= phy_speed_led_n; // RULE2
			if (led_mode)
			begin
				duplex_led_n_oe        <= phy_full_duplex; // RULE3
				link_activity_led_n_oe <= phy_link_up
					| phy_carrier; // RULE5
			end
			else
			begin
				duplex_led_n_oe        <= ~phy_speed_led_n; // RULE4
				link_activity_led_n_oe <= phy_carrier;  // RULE6
			end
		end
	end

	// 20 MHz divider for the external mii part
	lsp_clkdiv u_clkdiv (
		.mclk      (mclk),
		.nrst      (nrst),
		.clk_out_q (mii_clock_20m_out) // RULE14
	);

	// ahb address phase capture
	reg        dp_q;
	reg        dp_wr_q;
	reg [7:0]  dp_addr_q;
	wire       ap_go = hsel & hready & htrans[1];

	always @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			dp_q      <= 1'b0;
			dp_wr_q   <= 1'b0;
			dp_addr_q <= 8'h00;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
		else
		begin
			// one wait state on every read: a write whose data
			// phase overlaps the read's address phase lands first
			hreadyout <= ~(ap_go & ~hwrite);
			hresp     <= 1'b0;
			if (hready)
			begin
				dp_q      <= ap_go;
				dp_wr_q   <= ap_go & hwrite;
				dp_addr_q <= haddr;
			end
		end
	end

	// write lands at the end of its data phase
	wire wr_en = dp_q & dp_wr_q;
	// read data is taken in the wait cycle, from the captured address
	wire rd_en = dp_q & ~dp_wr_q & ~hreadyout;

	// software registers
	reg [3:0]          gpdir_q;
	reg [3:0]          gpval_q;
	reg [`LSP_IRQ_W-1:0] ist_q;
	reg [`LSP_IRQ_W-1:0] imask_q;
	reg                link_d1_q;
	reg                rdy_d1_q;
	reg                wake_q;
	wire [`LSP_IRQ_W-1:0] ev;

	// event sources into the sticky bits: wake_event as driven, link and ready edges as one-cycle pulses
	assign ev[`LSP_IRQ_WAKE]    = wake_event;
	assign ev[`LSP_IRQ_LINKCHG] = phy_link_up ^ link_d1_q;
	assign ev[`LSP_IRQ_READY]   = device_ready & ~rdy_d1_q;

	// general io and interrupt registers
	always @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			gpdir_q   <= `LSP_GPDIR_RST; // RULE7 RULE8
			gpval_q   <= `LSP_GPVAL_RST; // RULE7
			imask_q   <= {`LSP_IRQ_W{1'b0}};
			link_d1_q <= 1'b0;
			rdy_d1_q  <= 1'b0;
		end
		else
		begin
			link_d1_q <= phy_link_up;
			rdy_d1_q  <= device_ready;
			if (wr_en && dp_addr_q == `LSP_OFF_GPDIR)
				gpdir_q <= hwdata[3:0];
			else if (wr_en && dp_addr_q == `LSP_OFF_GPVAL)
				gpval_q <= hwdata[3:0];
			else if (wr_en && dp_addr_q == `LSP_OFF_IRQ_MASK)
				imask_q <= hwdata[`LSP_IRQ_W-1:0];
		end
	end

	// sticky status: a new event wins over a write-one clear
	genvar gi;
	generate
		for (gi = 0; gi < `LSP_IRQ_W; gi = gi + 1)
		begin : g_ist
			always @(posedge mclk or negedge nrst)
			begin
				if (!nrst)
					ist_q[gi] <= 1'b0;
				else if (ev[gi])
					ist_q[gi] <= 1'b1;
				else if (wr_en && dp_addr_q == `LSP_OFF_IRQ_STAT
					&& hwdata[gi])
					ist_q[gi] <= 1'b0;
			end
		end
	endgenerate

	// wake output held until software clears it via ctrl
	always @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			wake_q <= 1'b0;
		else if (wake_event)
			wake_q <= 1'b1; // RULE11
		else if (wr_en && dp_addr_q == `LSP_OFF_CTRL
			&& hwdata[`LSP_CTRL_WAKECLR])
			wake_q <= 1'b0;
	end

	// pin outputs from flops
	always @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			general_io_pins_o  <= `LSP_GPVAL_RST;
			general_io_pins_oe <= `LSP_GPDIR_RST;
			wake_signal_out    <= 1'b0;
			irq                <= 1'b0;
		end
		else
		begin
			general_io_pins_o  <= gpval_q;
			general_io_pins_oe <= gpdir_q;
			wake_signal_out    <= wake_q; // RULE11
			irq                <= |(ist_q & imask_q);
		end
	end

	// read mux, registered so data stands in the data phase
	reg [31:0] rd_d;
	always @*
	begin
		rd_d = 32'h00000000;
		if (dp_addr_q == `LSP_OFF_CTRL)
			rd_d[`LSP_CTRL_WAKECLR] = wake_q;
		else if (dp_addr_q == `LSP_OFF_STATUS)
		begin
			rd_d[`LSP_ST_READY]   = device_ready;
			rd_d[`LSP_ST_LEDMODE] = led_mode;
			rd_d[`LSP_ST_REVMII]  = reversed_mii;
			rd_d[`LSP_ST_LINK]    = phy_link_up;
			rd_d[`LSP_ST_SPEED]   = phy_speed_led_n;
			rd_d[`LSP_ST_FDX]     = phy_full_duplex;
			rd_d[`LSP_ST_CRS]     = phy_carrier;
			rd_d[`LSP_ST_TEST_LO+3:`LSP_ST_TEST_LO] = test_q;
		end
		else if (dp_addr_q == `LSP_OFF_GPDIR)
			rd_d[3:0] = gpdir_q;
		else if (dp_addr_q == `LSP_OFF_GPVAL)
			rd_d[3:0] = (gpval_q & gpdir_q) | (gpi2_q & ~gpdir_q);
		else if (dp_addr_q == `LSP_OFF_IRQ_STAT)
			rd_d[`LSP_IRQ_W-1:0] = ist_q;
		else if (dp_addr_q == `LSP_OFF_IRQ_MASK)
			rd_d[`LSP_IRQ_W-1:0] = imask_q;
	end

	// hrdata holds between reads, so a slow master still sees it
	always @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			hrdata <= 32'h00000000;
		else if (rd_en)
			hrdata <= rd_d;
	end
endmodule // lsp_pin_logic

// >>> testbench/lsp_properties.sv
`timescale 1ns/100ps
module lsp_checker #(
	parameter READY_CYC = 1000
) (
	input logic       mclk,
	input logic       nrst,
	input logic       hreadyout,
	input logic       hresp,
	input logic       phy_speed_led_n,
	input logic       phy_full_duplex,
	input logic       phy_link_up,
	input logic       phy_carrier,
	input logic       wake_event,
	input logic       speed_led_n_oe,
	input logic       duplex_led_n_oe,
	input logic       link_activity_led_n_oe,
	input logic [3:0] general_io_pins_o,
	input logic [3:0] general_io_pins_oe,
	input logic       cable_link_out,
	input logic       wake_signal_out,
	input logic       device_ready,
	input logic       led_mode,
	input logic       reversed_mii,
	input logic       mii_clock_20m_out
);
	logic [15:0] cnt_q;
	logic        rst_seen_q = 1'b0;
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	// edges since release, saturates so it never wraps
	always_ff @(posedge mclk or negedge nrst)
		if (!nrst) cnt_q <= 16'h0;
		else if (cnt_q != 16'hFFFF) cnt_q <= cnt_q + 16'h1;
	// second edge in reset: outputs have settled by then
	always @(posedge mclk)
		rst_seen_q <= !nrst;
	speed_led_a: assert property (
		nrst |=> speed_led_n_oe == $past(phy_speed_led_n)) else $error("speed led");
	bus_okay_a: assert property (!hresp) else $error("bus response");
	read_wait_a: assert property (!hreadyout |=> hreadyout)
		else $error("read wait too long");
	duplex_led_a: assert property (device_ready |=>
		duplex_led_n_oe == (led_mode ? $past(phy_full_duplex)
		: !$past(phy_speed_led_n))) else $error("duplex led");
	activity_led_a: assert property (device_ready |=>
		link_activity_led_n_oe == ($past(phy_carrier)
		| (led_mode & $past(phy_link_up)))) else $error("activity led");
	gp_reset_a: assert property (disable iff (1'b0)
		!nrst && rst_seen_q |-> general_io_pins_oe == 4'h1
		&& general_io_pins_o == 4'h1) else $error("io reset state");
	cable_link_a: assert property ($stable(phy_link_up) [*3] |->
		cable_link_out == phy_link_up) else $error("cable link");
	wake_out_a: assert property (wake_event |->
		##[1:2] wake_signal_out) else $error("wake output");
	ready_early_a: assert property (device_ready |->
		cnt_q >= READY_CYC) else $error("ready too soon");
	ready_late_a: assert property (cnt_q > READY_CYC + 1 |->
		device_ready) else $error("ready too late");
	strap_hold_a: assert property (device_ready |=>
		$stable(led_mode) && $stable(reversed_mii)) else $error("strap moved");
	clk20_a: assert property ($rose(mii_clock_20m_out) |=>
		mii_clock_20m_out [*4] ##1 !mii_clock_20m_out) else $error("clk20");
	cover property ($rose(device_ready));
	cover property ($rose(wake_signal_out));
	cover property (device_ready && led_mode && phy_link_up);
endmodule // lsp_checker

bind lsp_pin_logic lsp_checker #(.READY_CYC(READY_CYC)) u_lsp_checker (.*);

// >>> testbench/lsp_board.sv
`timescale 1ns/100ps
module lsp_board (
	input  logic       ee_strap,
	input  logic       rev_strap,
	input  logic [3:0] gp_ext,
	input  logic [2:0] led_o,
	input  logic [2:0] led_oe,
	input  logic [3:0] gp_o,
	input  logic [3:0] gp_oe,
	input  logic       cl_out,
	input  logic       cl_oe,
	output logic       ee_pin,
	output logic       cl_pin,
	output logic [3:0] test_pins,
	output logic [3:0] gp_pin,
	output logic [2:0] led_pin
);
	// leds hang off a pull-up, a released pin reads high
	assign led_pin = (led_oe & led_o) | ~led_oe;
	assign gp_pin = (gp_oe & gp_o) | (~gp_oe & gp_ext);
	// strap resistor shows only while the device lets go
	assign cl_pin = cl_oe ? cl_out : rev_strap;
	assign ee_pin = ee_strap;
	assign test_pins = 4'h3;
endmodule // lsp_board

// >>> testbench/test_led_strap_misc_pin_logic.sv
`timescale 1ns/100ps
module test_led_strap_misc_pin_logic;
	localparam RC = 20;
	logic        mclk = 1'b0, nrst = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic        wake = 1'b0, ee_s = 1'b0, rv_s = 1'b0, r;
	logic [7:0]  haddr = 8'h0;
	logic [1:0]  htrans = 2'h0;
	logic [31:0] hwdata = 32'h0, hrdata, rd;
	logic [3:0]  phy = 4'h0, gp_ext = 4'h0, dir, val;
	logic [3:0]  gp_o, gp_oe, gp_pin, test_pins;
	logic [2:0]  led_o, led_oe, led_pin;
	logic        hreadyout, irq, ee_pin, cl_pin, cl_out, cl_oe;
	logic        wake_out, rdy, mode, rev;
	integer      seed = 32'h63EB7A26, mismatches = 0, comparisons = 0;
	integer      i, n, cyc = 0;

	always #2.5 mclk = ~mclk;

	lsp_pin_logic #(.READY_CYC(RC)) u_lsp_pin_logic (.mclk(mclk),
		.nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(), .irq(irq), .phy_speed_led_n(phy[0]),
		.phy_full_duplex(phy[1]), .phy_link_up(phy[2]),
		.phy_carrier(phy[3]), .wake_event(wake),
		.eeprom_select_strap(ee_pin), .cable_link_in(cl_pin),
		.test_mode_straps(test_pins), .speed_led_n_o(led_o[0]),
		.speed_led_n_oe(led_oe[0]), .duplex_led_n_o(led_o[1]),
		.duplex_led_n_oe(led_oe[1]), .link_activity_led_n_o(led_o[2]),
		.link_activity_led_n_oe(led_oe[2]), .general_io_pins_i(gp_pin),
		.general_io_pins_o(gp_o), .general_io_pins_oe(gp_oe),
		.cable_link_out(cl_out), .cable_link_oe(cl_oe),
		.wake_signal_out(wake_out), .device_ready(rdy), .led_mode(mode),
		.reversed_mii(rev), .mii_clock_20m_out());

	lsp_board u_lsp_board (.ee_strap(ee_s), .rev_strap(rv_s),
		.gp_ext(gp_ext), .led_o(led_o), .led_oe(led_oe), .gp_o(gp_o),
		.gp_oe(gp_oe), .cl_out(cl_out), .cl_oe(cl_oe), .ee_pin(ee_pin),
		.cl_pin(cl_pin), .test_pins(test_pins), .gp_pin(gp_pin),
		.led_pin(led_pin));

	// led pin levels: low means lit
	function automatic logic [2:0] led_exp(input logic [3:0] p, input logic m);
		led_exp = ~{p[3] | (m & p[2]), m ? p[1] : !p[0], p[0]};
	endfunction

	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task finish_test;
		$display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// single word transfer, holds each phase until hready
	task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] q);
		@(posedge mclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask

	// let syncs and irq flop settle, sample away from the edge
	task settle;
		repeat (4) @(posedge mclk);
		#1;
	endtask

	// hang guard, the run needs far fewer cycles
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 8000)
		begin
			mismatches++;
			finish_test;
		end
	end

	initial
	begin
		for (i = 0; i < 2; i++)
		begin
			// second pass takes the other reversed mii strap level
			r = (i == 0) ? 1'($random(seed)) : !r;
			@(posedge mclk);
			nrst <= 1'b0;
			ee_s <= i[0];
			rv_s <= r;
			repeat (10) @(posedge mclk);
			nrst <= 1'b1;
			n = 0;
			while (rdy !== 1'b1 && n < 100)
			begin
				@(posedge mclk);
				n++;
			end
			chk(32'({gp_o, gp_oe}), 32'h11);
			ahb(1'b0, 8'h04, 32'h0, rd);
			chk(rd & 32'hF07, {20'h0, 4'h3, 5'h0, r, i[0], 1'b1});
			// flip the strap pins, sampled values must not move
			ee_s <= !i[0];
			rv_s <= !r;
			settle;
			chk(32'({mode, rev}), 32'({i[0], r}));
			// all sixteen phy states first, then random ones
			for (n = 0; n < 32; n++)
			begin
				@(posedge mclk);
				phy <= (n < 16) ? 4'(n) : 4'($random(seed));
				settle;
				chk(32'(led_pin), 32'(led_exp(phy, i[0])));
				chk(32'(cl_out), 32'(phy[2]));
			end
		end
		@(posedge mclk);
		wake <= 1'b1;
		@(posedge mclk);
		wake <= 1'b0;
		settle;
		chk(32'({wake_out, irq}), 32'h2);
		ahb(1'b1, 8'h14, 32'h1, rd);
		settle;
		chk(32'(irq), 32'h1);
		ahb(1'b1, 8'h10, 32'h1, rd);
		ahb(1'b1, 8'h00, 32'h1, rd);
		settle;
		chk(32'({wake_out, irq}), 32'h0);
		ahb(1'b0, 8'h1C, 32'h0, rd);
		chk(rd, 32'h0);
		for (n = 0; n < 6; n++)
		begin
			dir = 4'($random(seed));
			val = 4'($random(seed));
			gp_ext <= 4'($random(seed));
			ahb(1'b1, 8'h08, 32'(dir), rd);
			ahb(1'b1, 8'h0C, 32'(val), rd);
			settle;
			chk(32'({gp_oe, gp_pin}), 32'({dir, dir & val | ~dir & gp_ext}));
			ahb(1'b0, 8'h0C, 32'h0, rd);
			chk(rd & 32'hF, 32'(dir & val | ~dir & gp_ext));
		end
		finish_test;
	end
endmodule // test_led_strap_misc_pin_logic
